// File: inc/jcf_pkg.sv
// Purpose: Shared constants for the character FIFO bridge.
// Assumes: Word-indexed register port, 32-bit data.
// Notes:   Offsets are register indices on the bus address.
`default_nettype none
package jcf_pkg;
   // ==========================================================
   // Register map
   localparam logic [0:0] JCF_OFS_CHAR_PORT = 1'h0;
   localparam logic [0:0] JCF_OFS_IRQ_CTRL  = 1'h1;
   // ==========================================================
   // Field positions
   localparam int JCF_DATA_LSB      = 0;
   localparam int JCF_RVALID_BIT    = 15;
   localparam int JCF_COUNT_LSB     = 16;
   localparam int JCF_RX_EN_BIT     = 0;
   localparam int JCF_TX_EN_BIT     = 1;
   localparam int JCF_RX_PEND_BIT   = 8;
   localparam int JCF_TX_PEND_BIT   = 9;
   localparam int JCF_POLL_BIT      = 10;
   // ==========================================================
   // Reset values and defaults
   localparam logic JCF_EN_RESET    = 1'h0;
   localparam logic JCF_POLL_RESET  = 1'h0;
   localparam int   JCF_DEPTH_DFLT  = 64;
   localparam int   JCF_MARK_DFLT   = 8;
endpackage
`default_nettype wire

// File: verilog/jcf_fifo.sv
// Purpose: Synchronous character FIFO with occupancy count.
// Assumes: Single clock; push to a full FIFO is dropped by the FIFO's own guard.
// Notes:   Count width holds DEPTH itself.
`default_nettype none
module jcf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 64,
   parameter int CW    = $clog2(DEPTH + 1)
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             push,
   input  wire logic [WIDTH-1:0] push_data,
   input  wire logic             pop,
   output var  logic [WIDTH-1:0] head,
   output var  logic [CW-1:0]    count,
   output var  logic             full,
   output var  logic             empty
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   // Pointers and occupancy travel together as the FIFO's state
   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [CW-1:0] cnt;
   } jcf_fifo_state_t;

   jcf_fifo_state_t  st_q;
   jcf_fifo_state_t  st_d;
   logic             do_push;
   logic             do_pop;

   // ============================================================
   // Handshake qualification
   assign do_push = push && (st_q.cnt != DEPTH_C);
   assign do_pop  = pop && (st_q.cnt != '0);
   assign full    = (st_q.cnt == DEPTH_C);
   assign empty   = (st_q.cnt == '0);
   assign count   = st_q.cnt;
   assign head    = mem[st_q.rd];

   // Storage array, no reset needed
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[st_q.wr] <= push_data;
      end
   end

   // Next pointers and occupancy; wrap at DEPTH so any depth works
   always_comb begin
      st_d = st_q;
      if (do_push) begin
         st_d.wr = (st_q.wr == AW'(DEPTH - 1)) ? '0 : st_q.wr + 1'b1;
      end
      if (do_pop) begin
         st_d.rd = (st_q.rd == AW'(DEPTH - 1)) ? '0 : st_q.rd + 1'b1;
      end
      if (do_push && !do_pop) begin
         st_d.cnt = st_q.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
         st_d.cnt = st_q.cnt - 1'b1;
      end
   end

   // State register, cleared to empty
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule
`default_nettype wire

// File: verilog/jcf_bridge.sv
// Purpose: Bus slave moving characters between a processor and a host link.
// Assumes: Host side is same-clock logic with valid/ready character streams.
//          HOST_POLL and HOST_IDLE are levels on the bus clock, so no synchroniser is used.
// Notes:   Two word registers selected by ADDR; reads return data the same cycle.
//          A read pops at the strobe's edge, so its count field shows the fill after it.
//          A read of an empty port returns zero and leaves both FIFOs untouched.
//          Both thresholds are fixed at build time; software only sees their effect.
//
// Contract
// (R1) A character-port read returns the oldest receive character in [7:0] and pops it.
// (R2) Bit 15 of a character-port read is 1 only when [7:0] carries a real character.
// (R3) Bits [31:16] of a character-port read give receive fill left after that read.
// (R4) A character-port write pushes [7:0] to transmit, dropped silently when full.
// (R5) Software writes zero to reserved bits and ignores their read values.
// (R6) Control bits 0 and 1 are read/write receive and transmit interrupt enables.
// (R7) Control bits 8 and 9 show receive and transmit conditions gated by their enables.
// (R8) Bit 10 is set by a host poll and cleared only by writing 1 to it.
// (R9) Control bits [31:16] give the free entries of the transmit FIFO.
// (R10) IRQ is high whenever an enabled condition is pending.
// (R11) Transmit condition holds while transmit fill is at or below the fixed low mark.
// (R12) Receive condition holds while receive free space is at or below the high mark.
// (R13) Receive condition also holds with data present and no more host data expected.
// (R14) Software enables transmit interrupts after filling and disables when done.
// (R15) Control writes change only the enables, and clear the poll flag when bit 10 is 1.
// (R16) Both marks default to eight characters.
// (R17) Reset clears enables, poll flag and FIFOs; an empty read leaves state unchanged.
`default_nettype none
module jcf_bridge
   import jcf_pkg::*;
#(
   parameter int DEPTH        = JCF_DEPTH_DFLT,
   parameter int TX_LOW_MARK  = JCF_MARK_DFLT,   // (R16)
   parameter int RX_HIGH_MARK = JCF_MARK_DFLT    // (R16)
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RESET,
   input  wire logic        ADDR,
   input  wire logic        RD_EN,
   input  wire logic        WR_EN,
   input  wire logic [31:0] WR_DATA,
   output var  logic [31:0] RD_DATA,
   output var  logic        IRQ,
   input  wire logic        HOST_RX_VALID,
   output var  logic        HOST_RX_READY,
   input  wire logic [7:0]  HOST_RX_DATA,
   output var  logic        HOST_TX_VALID,
   input  wire logic        HOST_TX_READY,
   output var  logic [7:0]  HOST_TX_DATA,
   input  wire logic        HOST_POLL,
   input  wire logic        HOST_IDLE
);
   // Count width holds DEPTH itself; the marks are compared at that width
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
   localparam logic [CW-1:0] TX_MARK = CW'(TX_LOW_MARK);
   localparam logic [CW-1:0] RX_MARK = CW'(RX_HIGH_MARK);

   // Software-visible control state; all other status comes from the FIFOs and HOST_IDLE
   typedef struct packed {
      logic rx_irq_enable;
      logic tx_irq_enable;
      logic host_poll_seen;
   } jcf_state_t;

   jcf_state_t       st_q;
   jcf_state_t       st_d;
   logic [7:0]       rx_head;
   logic [CW-1:0]    rx_cnt;
   logic             rx_full;
   logic             rx_empty;
   logic [7:0]       tx_head;
   logic [CW-1:0]    tx_cnt;
   logic             tx_full;
   logic             tx_empty;

   // Bus strobes and stream qualification
   logic             rd_char;
   logic             wr_char;
   logic             wr_ctrl;
   logic             rx_pop;
   logic             rx_push;
   logic             tx_push;
   logic             tx_pop;
   logic             poll_clear;

   // Counts and interrupt status
   logic [CW-1:0]    rx_left;
   logic [CW-1:0]    rx_free;
   logic [CW-1:0]    tx_free;
   logic             rx_near_full;
   logic             rx_leftover;
   logic             rx_cond;
   logic             tx_cond;
   logic             rx_irq_pending;
   logic             tx_irq_pending;

   // Read words
   logic [31:0]      char_word;
   logic [31:0]      ctrl_word;

   // ============================================================
   // Receive FIFO: host fills, bus reads drain
   jcf_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_rx (
      .clk       (SYS_CLK),
      .rst       (RESET),
      .push      (rx_push),
      .push_data (HOST_RX_DATA),
      .pop       (rx_pop),
      .head      (rx_head),
      .count     (rx_cnt),
      .full      (rx_full),
      .empty     (rx_empty)
   );

   // ============================================================
   // Transmit FIFO: bus writes fill, host drains
   jcf_fifo #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_tx (
      .clk       (SYS_CLK),
      .rst       (RESET),
      .push      (tx_push),                                 // (R4)
      .push_data (WR_DATA[JCF_DATA_LSB +: 8]),              // (R4)
      .pop       (tx_pop),
      .head      (tx_head),
      .count     (tx_cnt),
      .full      (tx_full),
      .empty     (tx_empty)
   );

   // Host-facing handshakes; a character moves only on an edge with both sides high
   assign HOST_RX_READY = !rx_full;
   assign HOST_TX_VALID = !tx_empty;
   assign HOST_TX_DATA  = tx_head;
   assign rx_push       = HOST_RX_VALID && !rx_full;
   assign tx_pop        = HOST_TX_VALID && HOST_TX_READY;

   // ============================================================
   // Bus decode
   assign rd_char = RD_EN && (ADDR == JCF_OFS_CHAR_PORT);
   assign wr_char = WR_EN && (ADDR == JCF_OFS_CHAR_PORT);
   assign wr_ctrl = WR_EN && (ADDR == JCF_OFS_IRQ_CTRL);
   assign rx_pop  = rd_char && !rx_empty;                     // (R1) (R17)

   // A full transmit FIFO refuses the character here and again inside the FIFO
   assign tx_push = wr_char && !tx_full;                      // (R4)

   // The poll flag clears only on a control write with its bit set
   assign poll_clear = wr_ctrl && WR_DATA[JCF_POLL_BIT];      // (R8)

   // Counts shown to software; the pop lands at the edge, so the read reports the
   // fill after it and software never counts a character it already took
   assign rx_left = rx_pop ? rx_cnt - 1'b1 : rx_cnt;          // (R3)
   assign rx_free = DEPTH_C - rx_cnt;
   assign tx_free = DEPTH_C - tx_cnt;                         // (R9)

   // Transmit condition: the FIFO is at or below the low mark; it stays true while
   // the FIFO is low, so software enables it after filling and drops it when done
   assign tx_cond        = (tx_cnt <= TX_MARK);                         // (R11)

   // Receive condition: little free space left, or a leftover character while the
   // host has nothing more to send; draining the FIFO clears both
   assign rx_near_full   = (rx_free <= RX_MARK);                        // (R12)
   assign rx_leftover    = !rx_empty && HOST_IDLE;                      // (R13)
   assign rx_cond        = rx_near_full || rx_leftover;                 // (R12) (R13)

   // Pending flags are the conditions gated by their enables
   assign rx_irq_pending = rx_cond && st_q.rx_irq_enable;               // (R7)
   assign tx_irq_pending = tx_cond && st_q.tx_irq_enable;               // (R7)
   assign IRQ            = rx_irq_pending || tx_irq_pending;            // (R10)

   // ============================================================
   // Character port word: byte, valid flag and remaining fill
   always_comb begin
      char_word                       = '0;
      char_word[JCF_DATA_LSB +: 8]    = rx_empty ? 8'h00 : rx_head; // (R1)
      char_word[JCF_RVALID_BIT]       = !rx_empty;                  // (R2)
      char_word[31:JCF_COUNT_LSB]     = 16'(rx_left);               // (R3)
   end

   // Control word: enables, gated pending flags, poll flag and free space
   always_comb begin
      ctrl_word                       = '0;
      ctrl_word[JCF_RX_EN_BIT]        = st_q.rx_irq_enable;         // (R6)
      ctrl_word[JCF_TX_EN_BIT]        = st_q.tx_irq_enable;         // (R6)
      ctrl_word[JCF_RX_PEND_BIT]      = rx_irq_pending;             // (R7)
      ctrl_word[JCF_TX_PEND_BIT]      = tx_irq_pending;             // (R7)
      ctrl_word[JCF_POLL_BIT]         = st_q.host_poll_seen;        // (R8)
      ctrl_word[31:JCF_COUNT_LSB]     = 16'(tx_free);               // (R9)
   end

   // Read data mux; reserved bits and an empty byte read as zero
   always_comb begin
      if (ADDR == JCF_OFS_CHAR_PORT) begin
         RD_DATA = char_word;
      end else begin
         RD_DATA = ctrl_word;
      end
   end

   // Control state next value; a poll in the clear cycle wins
   always_comb begin
      st_d = st_q;
      if (wr_ctrl) begin
         st_d.rx_irq_enable = WR_DATA[JCF_RX_EN_BIT];                // (R6) (R15)
         st_d.tx_irq_enable = WR_DATA[JCF_TX_EN_BIT];                // (R6) (R15)
      end
      // Clear before set, so a poll in the same cycle keeps the flag up
      if (poll_clear) begin
         st_d.host_poll_seen = 1'b0;                                 // (R8)
      end
      if (HOST_POLL) begin
         st_d.host_poll_seen = 1'b1;                                 // (R8)
      end
   end

   // Control state register
   always_ff @(posedge SYS_CLK or posedge RESET) begin
      if (RESET) begin
         st_q <= '{rx_irq_enable:  JCF_EN_RESET,                     // (R17)
                   tx_irq_enable:  JCF_EN_RESET,
                   host_poll_seen: JCF_POLL_RESET};
      end else begin
         st_q <= st_d;
      end
   end
endmodule
`default_nettype wire

// File: bench/jcf_checker.sv
// Purpose: Port assertions for the character FIFO bridge.
// Assumes: Count fields are 16 bits wide.
// Notes:   Bound to jcf_bridge at the foot.
`default_nettype none
module jcf_checker #(
   parameter int DEPTH       = 64,
   parameter int TX_LOW_MARK = 8
) (
   input wire logic        SYS_CLK,
   input wire logic        RESET,
   input wire logic        ADDR,
   input wire logic        RD_EN,
   input wire logic        WR_EN,
   input wire logic [31:0] WR_DATA,
   input wire logic [31:0] RD_DATA,
   input wire logic        IRQ,
   input wire logic        HOST_RX_READY,
   input wire logic        HOST_TX_VALID,
   input wire logic [7:0]  HOST_TX_DATA,
   input wire logic        HOST_POLL
);
   timeunit 1ns;
   timeprecision 1ns;
   // ========================================
   // Register and stream relations
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   AST_IRQ: assert property (ADDR |-> IRQ == (RD_DATA[8] | RD_DATA[9]))
      else $error("irq differs from pending bits");
   AST_TX_PEND: assert property (ADDR |-> RD_DATA[9] ==
      (RD_DATA[1] && DEPTH - RD_DATA[31:16] <= TX_LOW_MARK)) else $error("tx pending wrong");
   AST_TX_FREE: assert property (ADDR |-> HOST_TX_VALID == (RD_DATA[31:16] != 16'(DEPTH)))
      else $error("tx free count wrong");
   AST_EMPTY_RD: assert property ((RD_EN && !ADDR && !RD_DATA[15]) |-> RD_DATA == 32'h0)
      else $error("empty read not zero");
   AST_FULL_RD: assert property ((RD_EN && !ADDR && !HOST_RX_READY) |->
      RD_DATA[15] && RD_DATA[31:16] == 16'(DEPTH - 1)) else $error("full read count wrong");
   AST_POLL_SET: assert property (HOST_POLL |=> (!ADDR || RD_DATA[10]))
      else $error("poll flag not set");
   AST_POLL_HOLD: assert property ((ADDR && RD_DATA[10] && !(WR_EN && WR_DATA[10])) ##1 ADDR
      |-> RD_DATA[10]) else $error("poll flag lost");
   AST_EN_WR: assert property ((WR_EN && ADDR) ##1 ADDR |-> RD_DATA[1:0] == $past(WR_DATA[1:0]))
      else $error("enables not written");
   AST_TX_PUSH: assert property ((WR_EN && !ADDR && !HOST_TX_VALID) |=>
      HOST_TX_VALID && HOST_TX_DATA == $past(WR_DATA[7:0])) else $error("tx push lost");
   // Main scenarios reached
   cover property ($rose(IRQ));
   cover property (RD_EN && !ADDR && !HOST_RX_READY);
   cover property (ADDR && RD_DATA[10] && WR_EN && WR_DATA[10]);
endmodule
bind jcf_bridge jcf_checker #(.DEPTH(DEPTH), .TX_LOW_MARK(TX_LOW_MARK)) u_chk (.*);
`default_nettype wire

// File: bench/jcf_host_model.sv
// Purpose: Host side: character source, sink, poll and idle.
// Assumes: Same clock as the bridge; drives at the falling edge.
// Notes:   Released data shows the inverse of the last byte.
`default_nettype none
module jcf_host_model (
   input  wire logic       clk,
   input  wire logic       rx_ready,
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output var  logic       rx_valid,
   output var  logic [7:0] rx_data,
   output var  logic       tx_ready,
   output var  logic       poll,
   output var  logic       idle
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got[$];
   int         timeouts = 0;
   // ========================================
   // Idle levels, then the sink keeps what it takes
   initial begin
      {rx_valid, rx_data, tx_ready, poll, idle} = 12'h0;
   end
   always @(posedge clk) if (tx_valid && tx_ready) got.push_back(tx_data);
   // Sends n bytes upward from first, each held until taken or 50 cycles pass
   task automatic send(input int n, input logic [7:0] first);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         rx_valid = 1'b1;
         rx_data = first + 8'(i);
         for (int k = 0; k < 50 && !rx_ready; k++) @(negedge clk);
         if (!rx_ready) timeouts++;
         @(posedge clk);
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_data = ~rx_data;
   endtask
   // Sets the sink's readiness and the host's idle level together
   task automatic set_levels(input logic ready, input logic quiet);
      @(negedge clk);
      tx_ready = ready;
      idle = quiet;
   endtask
   // One-cycle poll from the host
   task automatic pulse_poll();
      @(negedge clk) poll = 1'b1;
      @(negedge clk) poll = 1'b0;
   endtask
endmodule
`default_nettype wire

// File: bench/test_jtag_char_fifo_bridge.sv
// Purpose: Register-level test of the character FIFO bridge.
// Assumes: DEPTH 16, both marks 8.
// Notes:   Bus inputs change at the falling edge.
`default_nettype none
module test_jtag_char_fifo_bridge;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0, rst = 1'b1, addr = 1'b0, rd = 1'b0, wr = 1'b0;
   logic [31:0] wd = 32'h0, q;
   logic        irq, rxv, rxr, txv, txr, poll, idle;
   logic [7:0]  rxd, txd;
   int          errors = 0, comparisons = 0;
   always #10 clk = ~clk;
   jcf_bridge #(.DEPTH(16)) DUT (.SYS_CLK(clk), .RESET(rst), .ADDR(addr), .RD_EN(rd),
      .WR_EN(wr), .WR_DATA(wd), .RD_DATA(q), .IRQ(irq), .HOST_RX_VALID(rxv),
      .HOST_RX_READY(rxr), .HOST_RX_DATA(rxd), .HOST_TX_VALID(txv), .HOST_TX_READY(txr),
      .HOST_TX_DATA(txd), .HOST_POLL(poll), .HOST_IDLE(idle));
   jcf_host_model host (.clk(clk), .rx_ready(rxr), .tx_valid(txv), .tx_data(txd),
      .rx_valid(rxv), .rx_data(rxd), .tx_ready(txr), .poll(poll), .idle(idle));
   // ========================================
   // Compare, bus access and verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic a, input logic w, input logic [31:0] d, output logic [31:0] r);
      @(negedge clk);
      addr = a;
      wr = w;
      rd = !w;
      wd = d;
      #9 r = q;
      @(negedge clk);
      {rd, wr} = 2'b00;
   endtask
   task automatic rdc(input logic a, input logic [31:0] exp);
      logic [31:0] r;
      acc(a, 1'b0, 32'h0, r);
      chk(r, exp);
   endtask
   task automatic wrc(input logic a, input logic [31:0] d);
      logic [31:0] r;
      acc(a, 1'b1, d, r);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      rdc(1'b1, 32'h0010_0000);
      rdc(1'b0, 32'h0);
      $display("reset test done");
      host.send(3, 8'hA0);
      for (int i = 0; i < 3; i++) rdc(1'b0, {16'(2 - i), 8'h80, 8'hA0 + 8'(i)});
      rdc(1'b0, 32'h0);
      $display("receive test done");
      for (int i = 0; i < 17; i++) wrc(1'b0, 32'h40 + i);
      rdc(1'b1, 32'h0);
      host.set_levels(1'b1, 1'b0);
      for (int i = 0; i < 100 && host.got.size() < 16; i++) @(posedge clk);
      if (host.got.size() != 16) begin
         errors++;
         $display("[ERR] %0t transmit drain timed out", $time);
         give_verdict();
      end
      for (int i = 0; i < 16; i++) chk({24'h0, host.got[i]}, 32'h40 + i);
      $display("transmit test done");
      rdc(1'b1, 32'h0010_0000);
      host.set_levels(1'b0, 1'b0);
      for (int i = 0; i < 8; i++) wrc(1'b0, 32'h61);
      wrc(1'b1, 32'h0000_0303);
      rdc(1'b1, 32'h0008_0203);
      chk({31'h0, irq}, 32'h1);
      wrc(1'b0, 32'h62);
      rdc(1'b1, 32'h0007_0003);
      chk({31'h0, irq}, 32'h0);
      host.send(7, 8'hB0);
      rdc(1'b1, 32'h0007_0003);
      host.send(1, 8'hB7);
      rdc(1'b1, 32'h0007_0103);
      chk({31'h0, irq}, 32'h1);
      rdc(1'b0, {16'd7, 8'h80, 8'hB0});
      rdc(1'b1, 32'h0007_0003);
      host.set_levels(1'b0, 1'b1);
      rdc(1'b1, 32'h0007_0103);
      host.send(9, 8'hC0);
      rdc(1'b0, {16'd15, 8'h80, 8'hB1});
      wrc(1'b1, 32'h0);
      rdc(1'b1, 32'h0007_0000);
      chk({31'h0, irq}, 32'h0);
      $display("interrupt test done");
      host.pulse_poll();
      rdc(1'b1, 32'h0007_0400);
      wrc(1'b1, 32'h0);
      rdc(1'b1, 32'h0007_0400);
      wrc(1'b1, 32'h0000_0400);
      rdc(1'b1, 32'h0007_0000);
      fork
         host.pulse_poll();
         wrc(1'b1, 32'h0000_0400);
      join
      rdc(1'b1, 32'h0007_0400);
      $display("poll test done");
      wrc(1'b1, 32'h0000_0003);
      @(negedge clk) rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      rdc(1'b1, 32'h0010_0000);
      chk({31'h0, irq}, 32'h0);
      rdc(1'b0, 32'h0);
      $display("mid-run reset test done");
      if (host.timeouts != 0) begin
         errors++;
         $display("[ERR] %0t host send timed out", $time);
      end
      give_verdict();
   end
endmodule
`default_nettype wire
